// [input_capture_control_one.sv]
// Purpose: One input capture channel with control word, 16-bit counter and capture FIFO
// Assumes: Pin, idle, sleep and timer ticks are synchronous to mclk
// Notes: DEPTH must be a power of two; captures arriving while full are dropped
//
// Behaviour
// - Idle-halt bit stops the channel while the processor idles.
// - Timebase field picks system clock or a timer; codes 110 and 101 stop it.
// - Divider raises capture interrupt every first, second, third or fourth event.
// - Not-empty flag is high while unread captures remain.
// - Prescaled modes capture every rising edge, every 4th or every 16th.
// - Mode 000 switches the channel off.
// - Edge-detect mode captures both edges and interrupts on every event.
// - Interrupt-only mode makes the pin an interrupt source in sleep or idle.
// - The unused mode code leaves the channel disabled.
// - Unimplemented control bits read as zero.
// - Each capture event into a non-full FIFO stores the current counter value.
// - The FIFO holds up to four captured values.
// - Counter counts up freely and wraps from FFFF to 0000.
//
// The address-and-strobe port and the address map were left to the implementer.

`timescale 1ns/1ps

module input_capture_control_one #(
   parameter int DEPTH = 4,
   parameter int NUM_TIMERS = 5
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire capture_pkg::bus_req_s bus_req,
   output logic [15:0] rdata,
   input wire logic capture_pin,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   input wire logic [NUM_TIMERS-1:0] timer_tick,
   output logic irq
);

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_LVL = (PW+1)'(DEPTH);

   // ==========================================================
   // Declarations
   capture_pkg::ctrl_s ctrl_q;
   logic [15:0] count_q;
   logic pin_q;
   logic [3:0] pre_q;
   logic [1:0] div_q;
   logic [15:0] mem [DEPTH];
   logic [PW:0] wptr_q;
   logic [PW:0] rptr_q;
   logic overflow_q;
   logic [capture_pkg::STAT_W-1:0] status_q;
   logic [capture_pkg::STAT_W-1:0] mask_q;
   logic [capture_pkg::STAT_W-1:0] status_set;
   logic [15:0] rdata_q;
   logic irq_q;
   logic tick;
   logic halted;
   logic running;
   logic rise;
   logic fall;
   logic cap_ev;
   logic cap_irq_ev;
   logic pin_irq_ev;
   logic [PW:0] level;
   logic full;
   logic empty;
   logic push;
   logic pop;
   logic ctrl_wr;
   logic flush;
   logic [2:0] mode;

   // Register access decode, used by several processes
   function automatic logic hit(input capture_pkg::bus_req_s req, input logic [7:0] ofs);
      hit = (req.addr == ofs);
   endfunction : hit

   assign mode = ctrl_q.capture_mode_field;
   assign ctrl_wr = bus_req.wr & hit(bus_req, capture_pkg::CTRL_OFS);
   // Turning the channel off drops stale captures so a restart sees a clean FIFO
   assign flush = ctrl_wr & (bus_req.wdata[capture_pkg::MODE_LSB +: 3] == capture_pkg::MODE_OFF);

   // ==========================================================
   // Timebase and channel enable
   // Idle halt freezes counter and capture alike
   assign halted = ctrl_q.idle_halt_select & cpu_idle;

   // Reserved timebase codes give no tick, so the counter stands still
   always_comb begin
      tick = 1'b0;
      if (ctrl_q.timebase_select == capture_pkg::TB_SYSCLK) begin
         tick = 1'b1;
      end else if (ctrl_q.timebase_select == capture_pkg::TB_RSV6 ||
                   ctrl_q.timebase_select == capture_pkg::TB_RSV5) begin
         tick = 1'b0;
      end else if (int'(ctrl_q.timebase_select) < NUM_TIMERS) begin
         tick = timer_tick[ctrl_q.timebase_select];
      end
   end

   // Off, unused and interrupt-only modes keep the capture path idle
   always_comb begin
      running = 1'b0;
      if (mode == capture_pkg::MODE_OFF || mode == capture_pkg::MODE_UNUSED) begin
         running = 1'b0;
      end else if (mode == capture_pkg::MODE_INTONLY) begin
         running = 1'b0;
      end else begin
         running = ~halted;
      end
   end

   // Free-running counter, wraps naturally at 16 bits
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= capture_pkg::COUNT_RESET;
      end else if (running && tick) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // ==========================================================
   // Edge detection and prescaler
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= capture_pin;
      end
   end

   assign rise = capture_pin & ~pin_q;
   assign fall = ~capture_pin & pin_q;

   // Prescaler restarts on any control write so the 4th/16th count is exact
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= 4'h0;
      end else if (ctrl_wr) begin
         pre_q <= 4'h0;
      end else if (running && rise) begin
         if ((mode == capture_pkg::MODE_PRE4 && pre_q == capture_pkg::PRE4_LAST) ||
             (mode == capture_pkg::MODE_PRE16 && pre_q == capture_pkg::PRE16_LAST)) begin
            pre_q <= 4'h0;
         end else begin
            pre_q <= pre_q + 4'h1;
         end
      end
   end

   // Capture event selection per mode
   always_comb begin
      cap_ev = 1'b0;
      if (running) begin
         case (mode)
            capture_pkg::MODE_EDGE: cap_ev = rise | fall;
            capture_pkg::MODE_FALL: cap_ev = fall;
            capture_pkg::MODE_RISE: cap_ev = rise;
            capture_pkg::MODE_PRE4: cap_ev = rise & (pre_q == capture_pkg::PRE4_LAST);
            capture_pkg::MODE_PRE16: cap_ev = rise & (pre_q == capture_pkg::PRE16_LAST);
            default: cap_ev = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Capture FIFO
   assign level = wptr_q - rptr_q;
   assign full = (level == FULL_LVL);
   assign empty = (level == '0);
   assign push = cap_ev & ~full;
   assign pop = bus_req.rd & hit(bus_req, capture_pkg::FIFO_OFS) & ~empty;

   // Storage has no reset; only slots behind the write pointer are ever read
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wptr_q[PW-1:0]] <= count_q;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
      end else if (flush) begin
         wptr_q <= '0;
         rptr_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= rptr_q + 1'b1;
         end
      end
   end

   // Overflow sets on a capture into a full FIFO; a pop or flush clears it, set wins
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         overflow_q <= 1'b0;
      end else if (cap_ev && full) begin
         overflow_q <= 1'b1;
      end else if (pop || flush) begin
         overflow_q <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupt divider and events
   // Divider counts capture events; edge-detect mode bypasses it
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 2'h0;
      end else if (ctrl_wr) begin
         div_q <= 2'h0;
      end else if (cap_ev && mode != capture_pkg::MODE_EDGE) begin
         if (div_q == ctrl_q.interrupt_divider) begin
            div_q <= 2'h0;
         end else begin
            div_q <= div_q + 2'h1;
         end
      end
   end

   assign cap_irq_ev = cap_ev & ((mode == capture_pkg::MODE_EDGE) ||
                                 (div_q == ctrl_q.interrupt_divider));
   assign pin_irq_ev = rise & (cpu_sleep | cpu_idle) & (mode == capture_pkg::MODE_INTONLY);

   always_comb begin
      status_set = capture_pkg::STAT_RESET;
      status_set[capture_pkg::STAT_CAP] = cap_irq_ev;
      status_set[capture_pkg::STAT_OVF] = cap_ev & full;
      status_set[capture_pkg::STAT_PIN] = pin_irq_ev;
   end

   // Sticky status, write one to clear; a new event in the clear cycle survives
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= capture_pkg::STAT_RESET;
      end else if (bus_req.wr && hit(bus_req, capture_pkg::STATUS_OFS)) begin
         status_q <= (status_q & ~bus_req.wdata[capture_pkg::STAT_W-1:0]) | status_set;
      end else begin
         status_q <= status_q | status_set;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mask_q <= capture_pkg::STAT_RESET;
      end else if (bus_req.wr && hit(bus_req, capture_pkg::MASK_OFS)) begin
         mask_q <= bus_req.wdata[capture_pkg::STAT_W-1:0];
      end
   end

   // Interrupt level trails status by one cycle to come straight from a flop
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   // ==========================================================
   // Control register and read port
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= capture_pkg::CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q.idle_halt_select <= bus_req.wdata[capture_pkg::IDLE_BIT];
         ctrl_q.timebase_select <= bus_req.wdata[capture_pkg::TSEL_LSB +: 3];
         ctrl_q.interrupt_divider <= bus_req.wdata[capture_pkg::DIV_LSB +: 2];
         ctrl_q.capture_mode_field <= bus_req.wdata[capture_pkg::MODE_LSB +: 3];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 16'h0000;
      end else if (!bus_req.rd) begin
         rdata_q <= 16'h0000;
      end else if (hit(bus_req, capture_pkg::CTRL_OFS)) begin
         rdata_q <= 16'h0000;
         rdata_q[capture_pkg::IDLE_BIT] <= ctrl_q.idle_halt_select;
         rdata_q[capture_pkg::TSEL_LSB +: 3] <= ctrl_q.timebase_select;
         rdata_q[capture_pkg::DIV_LSB +: 2] <= ctrl_q.interrupt_divider;
         rdata_q[capture_pkg::OVF_BIT] <= overflow_q;
         rdata_q[capture_pkg::BNE_BIT] <= ~empty;
         rdata_q[capture_pkg::MODE_LSB +: 3] <= ctrl_q.capture_mode_field;
      end else if (hit(bus_req, capture_pkg::FIFO_OFS)) begin
         rdata_q <= empty ? 16'h0000 : mem[rptr_q[PW-1:0]];
      end else if (hit(bus_req, capture_pkg::COUNT_OFS)) begin
         rdata_q <= count_q;
      end else if (hit(bus_req, capture_pkg::STATUS_OFS)) begin
         rdata_q <= {13'h0000, status_q};
      end else if (hit(bus_req, capture_pkg::MASK_OFS)) begin
         rdata_q <= {13'h0000, mask_q};
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign rdata = rdata_q;
   assign irq = irq_q;

   // ==========================================================
   // Assertions
   a_counter_wraps: assert property (@(posedge mclk) disable iff (!arst_n)
      (running && tick && count_q == capture_pkg::COUNT_MAX) |=> count_q == 16'h0000)
      else $error("Counter did not wrap to zero");

   a_halt_freezes: assert property (@(posedge mclk) disable iff (!arst_n)
      (halted && !ctrl_wr) |=> (count_q == $past(count_q)) && !$past(push))
      else $error("Channel moved while idle halted");

   a_off_nocapture: assert property (@(posedge mclk) disable iff (!arst_n)
      (mode == capture_pkg::MODE_OFF || mode == capture_pkg::MODE_UNUSED) |-> !cap_ev && !running)
      else $error("Disabled mode captured");

   a_fifo_bounded: assert property (@(posedge mclk) disable iff (!arst_n)
      level <= FULL_LVL)
      else $error("FIFO level beyond depth");

   a_capture_stores: assert property (@(posedge mclk) disable iff (!arst_n)
      (push && empty && !pop && !flush) |=> mem[rptr_q[PW-1:0]] == $past(count_q))
      else $error("Captured value not the counter value");

   a_overflow_sets: assert property (@(posedge mclk) disable iff (!arst_n)
      (cap_ev && full && !pop && !flush) |=>
         overflow_q && status_q[capture_pkg::STAT_OVF] && level == FULL_LVL)
      else $error("Overflow not flagged on full FIFO");

   a_bne_reads: assert property (@(posedge mclk) disable iff (!arst_n)
      (bus_req.rd && hit(bus_req, capture_pkg::CTRL_OFS)) |=>
         rdata_q[capture_pkg::BNE_BIT] == ($past(level) != '0) &&
         rdata_q[15:14] == 2'h0 && rdata_q[9:7] == 3'h0)
      else $error("Control readback wrong");

   a_pop_advances: assert property (@(posedge mclk) disable iff (!arst_n)
      (pop && !flush) |=> rptr_q == $past(rptr_q) + 1'b1)
      else $error("Buffer read did not pop");

   a_edge_every: assert property (@(posedge mclk) disable iff (!arst_n)
      (mode == capture_pkg::MODE_EDGE && cap_ev) |=> status_q[capture_pkg::STAT_CAP])
      else $error("Edge mode missed an interrupt");

   a_div_zero: assert property (@(posedge mclk) disable iff (!arst_n)
      (ctrl_q.interrupt_divider == 2'h0 && cap_ev) |-> cap_irq_ev)
      else $error("Divider zero skipped an event");

   a_pre4_count: assert property (@(posedge mclk) disable iff (!arst_n)
      (mode == capture_pkg::MODE_PRE4 && cap_ev) |-> pre_q == capture_pkg::PRE4_LAST && rise)
      else $error("Prescale by four out of step");

   a_pin_only: assert property (@(posedge mclk) disable iff (!arst_n)
      (mode == capture_pkg::MODE_INTONLY) |->
         !push && (pin_irq_ev == (rise && (cpu_sleep || cpu_idle))))
      else $error("Interrupt-only mode misbehaved");

   a_irq_follows: assert property (@(posedge mclk) disable iff (!arst_n)
      (|(status_q & mask_q)) [*2] |-> irq_q)
      else $error("Interrupt not raised for masked-in status");

endmodule : input_capture_control_one

// [capture_pkg.sv]
// Purpose: Shared constants, field layout and carriers of the input capture channel
// Assumes: Byte addressed register port; one register per 32-bit word slot
// Notes: Capture mode and timebase codes are the hardware encodings of the control word

package capture_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FIFO_OFS = 8'h04;
   localparam logic [7:0] COUNT_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   localparam logic [7:0] MASK_OFS = 8'h10;

   // ==========================================================
   // Control word field positions
   localparam int IDLE_BIT = 13;
   localparam int TSEL_LSB = 10;
   localparam int DIV_LSB = 5;
   localparam int OVF_BIT = 4;
   localparam int BNE_BIT = 3;
   localparam int MODE_LSB = 0;

   // ==========================================================
   // Capture mode codes
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_EDGE = 3'h1;
   localparam logic [2:0] MODE_FALL = 3'h2;
   localparam logic [2:0] MODE_RISE = 3'h3;
   localparam logic [2:0] MODE_PRE4 = 3'h4;
   localparam logic [2:0] MODE_PRE16 = 3'h5;
   localparam logic [2:0] MODE_UNUSED = 3'h6;
   localparam logic [2:0] MODE_INTONLY = 3'h7;

   // ==========================================================
   // Timebase codes and prescaler terminal counts
   localparam logic [2:0] TB_SYSCLK = 3'h7;
   localparam logic [2:0] TB_RSV6 = 3'h6;
   localparam logic [2:0] TB_RSV5 = 3'h5;
   localparam logic [3:0] PRE4_LAST = 4'h3;
   localparam logic [3:0] PRE16_LAST = 4'hF;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // ==========================================================
   // Interrupt status bits
   localparam int STAT_W = 3;
   localparam int STAT_CAP = 0;
   localparam int STAT_OVF = 1;
   localparam int STAT_PIN = 2;
   localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic idle_halt_select;
      logic [2:0] timebase_select;
      logic [1:0] interrupt_divider;
      logic [2:0] capture_mode_field;
   } ctrl_s;

   localparam ctrl_s CTRL_RESET = '{1'b0, 3'h0, 2'h0, 3'h0};

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

endpackage : capture_pkg

// [capture_pin_model.sv]
// Purpose: Far-side model of the external capture input pin
// Assumes: The pin is synchronous to mclk, so it only changes after a rising edge
// Notes: Pulses stay high three cycles and low three, so no edge can be merged or missed

`timescale 1ns/1ps

module capture_pin_model (
   input wire logic mclk,
   output logic pin
);
   // Idle level is low between pulses
   initial pin = 1'b0;

   // ==========================================================
   // Pulse train of n rising edges, each followed by a falling edge
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         pin <= 1'b1;
         repeat (3) @(posedge mclk);
         pin <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask : pulses
endmodule : capture_pin_model

// [testbench.sv]
// Purpose: Self-checking bench for the input capture channel
// Assumes: Register port of capture_pkg; pin driven by capture_pin_model
// Notes: Timebase 000 with bench-made ticks keeps every captured value predictable

`timescale 1ns/1ps

module testbench;
   logic mclk;
   logic arst_n;
   capture_pkg::bus_req_s bus_req;
   logic [15:0] rdata;
   logic capture_pin;
   logic cpu_idle;
   logic cpu_sleep;
   logic [4:0] timer_tick;
   logic irq;
   logic [15:0] rv;
   logic [15:0] cnt;
   int n;
   int miscompares;
   int samples_checked;
   int cycles;

   // ==========================================================
   // Clock and hang guard; the wrap test alone needs some 65600 cycles
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         miscompares = miscompares + 1;
         test_done();
      end
   end

   // ==========================================================
   // Device under test and far-side pin
   input_capture_control_one u_input_capture_control_one (
      .mclk(mclk),
      .arst_n(arst_n),
      .bus_req(bus_req),
      .rdata(rdata),
      .capture_pin(capture_pin),
      .cpu_idle(cpu_idle),
      .cpu_sleep(cpu_sleep),
      .timer_tick(timer_tick),
      .irq(irq)
   );

   capture_pin_model u_capture_pin_model (
      .mclk(mclk),
      .pin(capture_pin)
   );

   // ==========================================================
   // Register port tasks: strobes last one cycle, read data taken the cycle after
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk);
      bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string s);
      rd(a, rv);
      chk(s, e, rv);
   endtask : rchk

   // Interrupt is registered, so let one edge land before looking
   task automatic irqchk(input logic e);
      @(posedge mclk);
      #1;
      chk("irq", {15'h0000, e}, {15'h0000, irq});
   endtask : irqchk

   task automatic tick(input logic [4:0] m);
      @(posedge mclk);
      timer_tick <= m;
      @(posedge mclk);
      timer_tick <= 5'h00;
   endtask : tick

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done

   // ==========================================================
   // Main sequence
   initial begin
      arst_n = 1'b0;
      bus_req = '0;
      cpu_idle = 1'b0;
      cpu_sleep = 1'b0;
      timer_tick = 5'h00;
      cnt = 16'h0000;
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;

      // Reset values, writable fields and holes in the map
      rchk(capture_pkg::CTRL_OFS, 16'h0000, "ctrl reset");
      rchk(capture_pkg::STATUS_OFS, 16'h0000, "status reset");
      wr(capture_pkg::CTRL_OFS, 16'hFFFF);
      rchk(capture_pkg::CTRL_OFS, 16'h3C67, "ctrl ones");
      wr(capture_pkg::MASK_OFS, 16'h0007);
      rchk(capture_pkg::MASK_OFS, 16'h0007, "mask");
      wr(8'h14, 16'hFFFF);
      rchk(8'h14, 16'h0000, "unmapped");
      $display("test registers done");

      // Each timer code counts only on its own tick; reserved codes never count
      for (int c = 0; c < 5; c++) begin
         wr(capture_pkg::CTRL_OFS, 16'(c << 10) | 16'h0003);
         tick(~(5'h01 << c));
         tick(5'h01 << c);
         cnt = cnt + 16'h0001;
         rchk(capture_pkg::COUNT_OFS, cnt, "count tb");
      end
      for (int c = 5; c < 7; c++) begin
         wr(capture_pkg::CTRL_OFS, 16'(c << 10) | 16'h0003);
         tick(5'h1F);
         rchk(capture_pkg::COUNT_OFS, cnt, "count rsv");
      end
      $display("test timebase done");

      // Five captures into four places: oldest first, fifth dropped as overflow
      wr(capture_pkg::CTRL_OFS, 16'h0003);
      for (int i = 0; i < 5; i++) begin
         u_capture_pin_model.pulses(1);
         tick(5'h01);
      end
      rchk(capture_pkg::CTRL_OFS, 16'h001B, "ovf bne");
      rchk(capture_pkg::STATUS_OFS, 16'h0003, "status ovf");
      for (int i = 0; i < 4; i++) begin
         rchk(capture_pkg::FIFO_OFS, cnt + 16'(i), "fifo");
      end
      rchk(capture_pkg::CTRL_OFS, 16'h0003, "drained");
      rchk(capture_pkg::FIFO_OFS, 16'h0000, "empty read");
      cnt = cnt + 16'h0005;
      irqchk(1'b1);
      wr(capture_pkg::MASK_OFS, 16'h0000);
      irqchk(1'b0);
      wr(capture_pkg::MASK_OFS, 16'h0001);
      $display("test fifo done");

      // Divider: status stays clear until capture number d+1
      for (int d = 0; d < 4; d++) begin
         wr(capture_pkg::CTRL_OFS, 16'(d << 5) | 16'h0003);
         wr(capture_pkg::STATUS_OFS, 16'h0007);
         u_capture_pin_model.pulses(d);
         rchk(capture_pkg::STATUS_OFS, 16'h0000, "div early");
         u_capture_pin_model.pulses(1);
         rchk(capture_pkg::STATUS_OFS, 16'h0001, "div hit");
         irqchk(1'b1);
         repeat (d + 1) rd(capture_pkg::FIFO_OFS, rv);
      end
      $display("test divider done");

      // Both edges captured, divider of four ignored
      wr(capture_pkg::CTRL_OFS, 16'h0061);
      wr(capture_pkg::STATUS_OFS, 16'h0007);
      u_capture_pin_model.pulses(1);
      rchk(capture_pkg::STATUS_OFS, 16'h0001, "edge irq");
      rchk(capture_pkg::FIFO_OFS, cnt, "edge rise");
      rchk(capture_pkg::FIFO_OFS, cnt, "edge fall");
      rchk(capture_pkg::CTRL_OFS, 16'h0061, "edge empty");
      // Falling-edge mode: one pulse gives exactly one entry, taken at the fall
      wr(capture_pkg::CTRL_OFS, 16'h0002);
      u_capture_pin_model.pulses(1);
      rchk(capture_pkg::FIFO_OFS, cnt, "fall value");
      rchk(capture_pkg::CTRL_OFS, 16'h0002, "fall once");
      $display("test edge done");

      // Prescaled modes: every 1st, 4th and 16th rising edge
      for (int m = 0; m < 3; m++) begin
         n = (m == 0) ? 1 : (m == 1) ? 4 : 16;
         wr(capture_pkg::CTRL_OFS, 16'h0003 + 16'(m));
         u_capture_pin_model.pulses(n - 1);
         rchk(capture_pkg::CTRL_OFS, 16'h0003 + 16'(m), "pre early");
         u_capture_pin_model.pulses(1);
         rchk(capture_pkg::CTRL_OFS, 16'h000B + 16'(m), "pre hit");
         rchk(capture_pkg::FIFO_OFS, cnt, "pre value");
      end
      $display("test prescale done");

      // Off and unused codes capture nothing
      for (int m = 0; m < 2; m++) begin
         wr(capture_pkg::CTRL_OFS, 16'(m * 6));
         wr(capture_pkg::STATUS_OFS, 16'h0007);
         u_capture_pin_model.pulses(2);
         rchk(capture_pkg::CTRL_OFS, 16'(m * 6), "off bne");
         rchk(capture_pkg::STATUS_OFS, 16'h0000, "off status");
      end
      $display("test off done");

      // Interrupt-only: pin interrupts while asleep but not while awake, and never fills the buffer
      wr(capture_pkg::CTRL_OFS, 16'h0007);
      u_capture_pin_model.pulses(1);
      rchk(capture_pkg::STATUS_OFS, 16'h0000, "awake pin");
      @(posedge mclk);
      cpu_sleep <= 1'b1;
      u_capture_pin_model.pulses(1);
      cpu_sleep <= 1'b0;
      rchk(capture_pkg::STATUS_OFS, 16'h0004, "sleep pin");
      rchk(capture_pkg::CTRL_OFS, 16'h0007, "intonly bne");
      $display("test intonly done");

      // Idle halt stops both capture and counting until idle ends
      wr(capture_pkg::CTRL_OFS, 16'h2003);
      cpu_idle <= 1'b1;
      u_capture_pin_model.pulses(1);
      tick(5'h01);
      rchk(capture_pkg::CTRL_OFS, 16'h2003, "idle halt");
      @(posedge mclk);
      cpu_idle <= 1'b0;
      u_capture_pin_model.pulses(1);
      rchk(capture_pkg::FIFO_OFS, cnt, "idle run");
      // Without the halt bit the channel keeps capturing through idle
      wr(capture_pkg::CTRL_OFS, 16'h0003);
      cpu_idle <= 1'b1;
      u_capture_pin_model.pulses(1);
      cpu_idle <= 1'b0;
      rchk(capture_pkg::FIFO_OFS, cnt, "idle keeps");
      $display("test idle done");

      // System clock timebase: 65536 cycles later the counter is back where it was
      wr(capture_pkg::CTRL_OFS, 16'h1C03);
      rd(capture_pkg::COUNT_OFS, cnt);
      repeat (65534) @(posedge mclk);
      rchk(capture_pkg::COUNT_OFS, cnt, "wrap");
      $display("test wrap done");
      test_done();
   end
endmodule : testbench
